// >>> common/aso_pkg.sv
// Shared constants and types for the sequence and oversampling converter control block.
package aso_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  STATUS_OFS      = 8'h00;
  localparam logic [7:0]  CONTROL_OFS     = 8'h08;
  localparam logic [7:0]  SEQ_12_15_OFS   = 8'h2c;
  localparam logic [7:0]  SEQ_6_11_OFS    = 8'h30;
  localparam logic [7:0]  SEQ_0_5_OFS     = 8'h34;
  localparam logic [7:0]  DATA_OFS        = 8'h4c;
  localparam logic [7:0]  OVS_CTRL_OFS    = 8'h80;

  localparam logic [31:0] REG_RESET       = 32'h0000_0000;
  localparam logic [31:0] SEQ_LOW_MASK    = 32'h3fff_ffff;
  localparam logic [31:0] SEQ_HIGH_MASK   = 32'h00ff_ffff;
  localparam logic [31:0] OVS_CTRL_MASK   = 32'h0000_33fd;
  localparam logic [3:0]  FULL_STROBE     = 4'hf;

  localparam int          SLOT_W          = 5;
  localparam int          NUM_SLOTS       = 16;
  localparam int          SLOTS_PER_WORD  = 6;
  localparam int          SLOTS_IN_HIGH   = 4;
  localparam int          SLOT_BITS_HIGH  = 20;
  localparam int          SLOT_BITS_LOW   = 30;
  localparam logic [4:0]  MAX_CHANNEL     = 5'h11;
  localparam int          SEQ_LEN_LSB     = 20;
  localparam int          SEQ_LEN_W       = 4;

  localparam int          OVS_EN_BIT      = 0;
  localparam int          OVS_RATIO_LSB   = 2;
  localparam int          OVS_SHIFT_LSB   = 5;
  localparam int          OVS_TRIG_BIT    = 9;
  localparam int          OVS_RES_LSB     = 12;

  localparam int          CTRL_ON_BIT     = 0;
  localparam int          CTRL_SWTRIG_BIT = 1;
  localparam int          STAT_EOC_BIT    = 0;
  localparam int          STAT_EOS_BIT    = 1;
  localparam int          STAT_BUSY_BIT   = 2;

  localparam int          SAMPLE_W        = 12;
  localparam int          ACC_W           = 20;
  localparam int          RESULT_W        = 16;
  localparam int          COUNT_W         = 9;
  localparam logic [3:0]  MAX_SHIFT       = 4'h8;

  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01,
    SEQ_WAIT = 2'b11,
    SEQ_ARM  = 2'b10
  } aso_seq_e;
endpackage

// >>> src/aso_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time, turned into simple strobes.
`timescale 1ns/10ps
module aso_axil_slave
  import aso_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output      logic              wr_en,
  output      logic [ADDR_W-1:0] wr_addr,
  output      logic [31:0]       wr_data,
  output      logic [3:0]        wr_strb,
  input  wire logic              wr_err,
  output      logic              rd_en,
  output      logic [ADDR_W-1:0] rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_err
);
  logic aw_held;
  logic w_held;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  // The store waits for a pending response so that responses never overlap.
  assign wr_en         = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_en         = s_axi_arvalid && s_axi_arready;
  assign rd_addr       = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr      <= '0;
      wr_data      <= '0;
      wr_strb      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> src/aso_oversampler.sv
// Resolution reduction, accumulation and right shift of raw conversion samples.
`timescale 1ns/10ps
module aso_oversampler
  import aso_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                clear,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample,
  input  wire logic [1:0]          resolution,
  input  wire logic                enable,
  input  wire logic [2:0]          ratio,
  input  wire logic [3:0]          shift,
  output      logic                last_sample,
  output      logic                result_valid,
  output      logic [RESULT_W-1:0] result
);
  logic [ACC_W-1:0]    acc;
  logic [COUNT_W-1:0]  count;
  logic [COUNT_W-1:0]  ratio_last;
  logic [SAMPLE_W-1:0] trimmed;
  logic [ACC_W-1:0]    sum;
  logic [3:0]          shift_eff;
  logic [ACC_W-1:0]    shifted;

  // Each resolution step drops two low bits of the raw sample.
  assign trimmed     = sample >> {resolution, 1'b0};
  // Ratio code n gives 2 << n samples per result.
  assign ratio_last  = COUNT_W'((2 << ratio) - 1);
  assign sum         = acc + {{(ACC_W-SAMPLE_W){1'b0}}, trimmed};
  // Reserved shift codes behave as the largest legal shift.
  assign shift_eff   = (shift > MAX_SHIFT) ? MAX_SHIFT : shift;
  assign shifted     = sum >> shift_eff;
  assign last_sample = !enable || (count == ratio_last);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc          <= '0;
      count        <= '0;
      result       <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (clear) begin
        acc   <= '0;
        count <= '0;
      end else if (sample_valid) begin
        if (!enable) begin
          result       <= RESULT_W'(trimmed);
          result_valid <= 1'b1;
        end else if (last_sample) begin
          result       <= shifted[RESULT_W-1:0];
          result_valid <= 1'b1;
          acc          <= '0;
          count        <= '0;
        end else begin
          acc   <= sum;
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule

// >>> src/aso_top.sv
// Routine sequence, result data and oversampling control of one converter instance.
//
// Notes on behaviour
// - Each 5-bit sequence slot holds a channel 0 to 17 and slot n picks the channel of the nth result.
// - The slots 0-5 word and the slots 6-11 word pack six 5-bit slots from bit 0 with the top two bits reserved.
// - A sequence runs the 4-bit length field plus one slots, one result each, taking channels from slot 0 upward.
// - The low 16 data bits show the latest routine result and writes to them change nothing.
// - In the first instance in synchronized dual mode the high 16 data bits carry the partner result, else zero.
// - The 2-bit resolution code selects 12, 10, 8 or 6 result bits for codes 00 to 11.
// - With triggered oversampling clear, all conversions of an oversampled channel follow one trigger.
// - With triggered oversampling set, every conversion of an oversampled channel waits for its own trigger.
// - The 4-bit shift code right-shifts the accumulated sum by 0 to 8 bits and codes above 8 are reserved.
// - The 3-bit ratio code selects 2 to 256 samples per result, doubling with each code.
// - Bit 0 of the oversample control word enables the oversampler, and clearing it bypasses it.
`timescale 1ns/10ps
module aso_top
  import aso_pkg::*;
#(
  parameter bit FIRST_CONVERTER = 1'b1
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output      logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output      logic                s_axi_wready,
  output      logic [1:0]          s_axi_bresp,
  output      logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output      logic                s_axi_arready,
  output      logic [31:0]         s_axi_rdata,
  output      logic [1:0]          s_axi_rresp,
  output      logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                routine_trigger,
  output      logic                conv_start,
  input  wire logic                conv_ready,
  output      logic [SLOT_W-1:0]   conv_channel,
  input  wire logic                conv_done,
  input  wire logic [SAMPLE_W-1:0] conv_sample,
  input  wire logic                dual_sync_mode,
  input  wire logic [RESULT_W-1:0] partner_converter_result,
  output      logic [RESULT_W-1:0] routine_result,
  output      logic                converter_on
);
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_err;

  aso_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // Software registers.
  logic [31:0] seq_slots_12_15;
  logic [31:0] routine_seq_slots_6_11;
  logic [31:0] routine_seq_slots_0_5;
  logic [31:0] oversample_control;
  logic [RESULT_W-1:0] data_high;
  logic        flag_eoc;
  logic        flag_eos;
  logic        sw_trigger;

  // A slot write carrying a channel above the last one keeps that slot's old channel.
  function automatic logic [31:0] keep_legal(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input int fields);
    logic [31:0] res;
    res = new_v;
    for (int i = 0; i < SLOTS_PER_WORD; i++) begin
      if (i < fields && new_v[i*SLOT_W +: SLOT_W] > MAX_CHANNEL) begin
        res[i*SLOT_W +: SLOT_W] = old_v[i*SLOT_W +: SLOT_W];
      end
    end
    return res;
  endfunction

  wire hit_status  = (wr_addr == STATUS_OFS);
  wire hit_control = (wr_addr == CONTROL_OFS);
  wire hit_seq_hi  = (wr_addr == SEQ_12_15_OFS);
  wire hit_seq_mid = (wr_addr == SEQ_6_11_OFS);
  wire hit_seq_lo  = (wr_addr == SEQ_0_5_OFS);
  wire hit_data    = (wr_addr == DATA_OFS);
  wire hit_ovs     = (wr_addr == OVS_CTRL_OFS);
  wire wr_mapped   = hit_status | hit_control | hit_seq_hi | hit_seq_mid | hit_seq_lo | hit_data | hit_ovs;
  wire wr_full     = (wr_strb == FULL_STROBE);
  // Partial-word writes are refused and store nothing.
  assign wr_err    = !wr_mapped || !wr_full;
  wire wr_ok       = wr_en && !wr_err;

  wire [31:0] seq_hi_next  = keep_legal(seq_slots_12_15, wr_data, SLOTS_IN_HIGH) & SEQ_HIGH_MASK;
  wire [31:0] seq_mid_next = keep_legal(routine_seq_slots_6_11, wr_data, SLOTS_PER_WORD) & SEQ_LOW_MASK;
  wire [31:0] seq_lo_next  = keep_legal(routine_seq_slots_0_5, wr_data, SLOTS_PER_WORD) & SEQ_LOW_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_slots_12_15        <= REG_RESET;
      routine_seq_slots_6_11 <= REG_RESET;
      routine_seq_slots_0_5  <= REG_RESET;
      oversample_control     <= REG_RESET;
      converter_on           <= 1'b0;
      sw_trigger             <= 1'b0;
    end else begin
      sw_trigger <= wr_ok && hit_control && wr_data[CTRL_SWTRIG_BIT];
      if (wr_ok && hit_seq_hi) begin
        seq_slots_12_15 <= seq_hi_next;
      end
      if (wr_ok && hit_seq_mid) begin
        routine_seq_slots_6_11 <= seq_mid_next;
      end
      if (wr_ok && hit_seq_lo) begin
        routine_seq_slots_0_5 <= seq_lo_next;
      end
      if (wr_ok && hit_ovs) begin
        oversample_control <= wr_data & OVS_CTRL_MASK;
      end
      if (wr_ok && hit_control) begin
        converter_on <= wr_data[CTRL_ON_BIT];
      end
    end
  end

  // Oversampler configuration, trusted to change only while the converter is off.
  wire       oversampler_enable     = oversample_control[OVS_EN_BIT];
  wire [2:0] oversample_ratio       = oversample_control[OVS_RATIO_LSB +: 3];
  wire [3:0] oversample_shift       = oversample_control[OVS_SHIFT_LSB +: 4];
  wire       triggered_oversampling = oversample_control[OVS_TRIG_BIT];
  wire [1:0] result_resolution      = oversample_control[OVS_RES_LSB +: 2];
  wire [SEQ_LEN_W-1:0] seq_length_field = seq_slots_12_15[SEQ_LEN_LSB +: SEQ_LEN_W];

  // Slot n of the sequence, slot 0 at bit 0 of the slots 0-5 word.
  wire [NUM_SLOTS*SLOT_W-1:0] slot_bits = {seq_slots_12_15[SLOT_BITS_HIGH-1:0],
                                           routine_seq_slots_6_11[SLOT_BITS_LOW-1:0],
                                           routine_seq_slots_0_5[SLOT_BITS_LOW-1:0]};
  logic [SLOT_W-1:0] seq_slot_channel [NUM_SLOTS];
  genvar g;
  for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
    assign seq_slot_channel[g] = slot_bits[g*SLOT_W +: SLOT_W];
  end

  // Sequencer.
  aso_seq_e            state;
  aso_seq_e            next_state;
  logic [SEQ_LEN_W-1:0] slot;
  logic [SEQ_LEN_W-1:0] next_slot;
  logic                 ovs_last;
  logic                 ovs_valid;
  logic [RESULT_W-1:0]  ovs_result;

  wire trigger      = routine_trigger | sw_trigger;
  wire sample_taken = (state == SEQ_WAIT) && conv_done;
  // sequence ends after length plus one
  wire seq_finished = sample_taken && ovs_last && (slot == seq_length_field);
  wire wait_trigger = triggered_oversampling && oversampler_enable;

  assign conv_start = (state == SEQ_CONV);

  always_comb begin
    next_state = state;
    next_slot  = slot;
    case (state)
      SEQ_IDLE: begin
        next_slot = '0;
        if (converter_on && trigger) begin
          next_state = SEQ_CONV;
        end
      end
      SEQ_CONV: begin
        if (!converter_on) begin
          next_state = SEQ_IDLE;
        end else if (conv_ready) begin
          next_state = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (!converter_on || seq_finished) begin
          next_state = SEQ_IDLE;
          next_slot  = '0;
        end else if (conv_done) begin
          if (ovs_last) begin
            next_slot = slot + 1'b1;
          end
          next_state = wait_trigger ? SEQ_ARM : SEQ_CONV;
        end
      end
      SEQ_ARM: begin
        if (!converter_on) begin
          next_state = SEQ_IDLE;
        end else if (trigger) begin
          next_state = SEQ_CONV;
        end
      end
      default: begin
        next_state = SEQ_IDLE;
        next_slot  = '0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state        <= SEQ_IDLE;
      slot         <= '0;
      conv_channel <= '0;
    end else begin
      state        <= next_state;
      slot         <= next_slot;
      conv_channel <= seq_slot_channel[next_slot];
    end
  end

  aso_oversampler u_ovs (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .clear        (!converter_on),
    .sample_valid (sample_taken),
    .sample       (conv_sample),
    .resolution   (result_resolution),
    .enable       (oversampler_enable),
    .ratio        (oversample_ratio),
    .shift        (oversample_shift),
    .last_sample  (ovs_last),
    .result_valid (ovs_valid),
    .result       (ovs_result)
  );

  // Result data and sticky status; a new event beats a clear in the same cycle.
  wire partner_on = FIRST_CONVERTER && dual_sync_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      routine_result <= '0;
      data_high      <= '0;
      flag_eoc       <= 1'b0;
      flag_eos       <= 1'b0;
    end else begin
      if (ovs_valid) begin
        routine_result <= ovs_result;
        data_high      <= partner_on ? partner_converter_result : '0;
      end
      if (ovs_valid) begin
        flag_eoc <= 1'b1;
      end else if (wr_ok && hit_status && wr_data[STAT_EOC_BIT]) begin
        flag_eoc <= 1'b0;
      end
      if (seq_finished) begin
        flag_eos <= 1'b1;
      end else if (wr_ok && hit_status && wr_data[STAT_EOS_BIT]) begin
        flag_eos <= 1'b0;
      end
    end
  end

  // Read decode.
  wire [31:0] status_word  = {29'h0, (state != SEQ_IDLE), flag_eos, flag_eoc};
  wire [31:0] control_word = {31'h0, converter_on};
  wire        rd_mapped    = (rd_addr == STATUS_OFS) || (rd_addr == CONTROL_OFS) || (rd_addr == SEQ_12_15_OFS) ||
                             (rd_addr == SEQ_6_11_OFS) || (rd_addr == SEQ_0_5_OFS) || (rd_addr == DATA_OFS) ||
                             (rd_addr == OVS_CTRL_OFS);
  assign rd_err  = !rd_mapped;
  assign rd_data = (rd_addr == STATUS_OFS)    ? status_word :
                   (rd_addr == CONTROL_OFS)   ? control_word :
                   (rd_addr == SEQ_12_15_OFS) ? seq_slots_12_15 :
                   (rd_addr == SEQ_6_11_OFS)  ? routine_seq_slots_6_11 :
                   (rd_addr == SEQ_0_5_OFS)   ? routine_seq_slots_0_5 :
                   (rd_addr == DATA_OFS)      ? {data_high, routine_result} :
                   (rd_addr == OVS_CTRL_OFS)  ? oversample_control : 32'h0000_0000;
endmodule

// >>> sim/aso_asserts.sv
// Checker for bus handshakes and conversion timing at the converter control ports.
`timescale 1ns/10ps
module aso_asserts
  import aso_pkg::*;
(
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic                conv_start,
  input wire logic                conv_ready,
  input wire logic [SLOT_W-1:0]   conv_channel,
  input wire logic                conv_done,
  input wire logic [RESULT_W-1:0] routine_result
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |-> ##2 s_axi_bvalid) else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_start_hold: assert property (conv_start && !conv_ready |=> conv_start && $stable(conv_channel))
    else $error("request dropped");
  a_chan_range: assert property (conv_start |-> conv_channel <= MAX_CHANNEL)
    else $error("channel out of range");
  // A result may only move two edges after a finished conversion; reset clears it quietly.
  a_result_cause: assert property ($past(aresetn) && !$stable(routine_result) |-> $past(conv_done, 2))
    else $error("result changed without conversion");

  c_conv: cover property (conv_start && conv_ready);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_result: cover property (conv_done ##2 !$stable(routine_result));
endmodule

bind aso_top aso_asserts u_asserts (.*);

// >>> sim/aso_core_model.sv
// Behavioural analog conversion core answering requests with raw samples.
`timescale 1ns/10ps
module aso_core_model
  import aso_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                conv_start,
  output      logic                conv_ready,
  output      logic                conv_done,
  output      logic [SAMPLE_W-1:0] conv_sample
);
  logic [SAMPLE_W-1:0] next_s;
  bit                  slow;

  initial begin
    conv_ready = 1'b0;
    conv_done = 1'b0;
    conv_sample = 12'h000;
    next_s = 12'h5a3;
    forever begin
      @(posedge aclk);
      if (conv_start) begin
        // Alternating prompt and slow answers so both timings reach the sequencer.
        slow = !slow;
        if (slow) repeat (2) @(posedge aclk);
        conv_ready <= 1'b1;
        @(posedge aclk);
        conv_ready <= 1'b0;
        repeat (slow ? 3 : 1) @(posedge aclk);
        next_s = 12'(next_s * 5 + 12'h2b);
        conv_done <= 1'b1;
        conv_sample <= next_s;
        @(posedge aclk);
        conv_done <= 1'b0;
        conv_sample <= ~next_s;
      end
    end
  end
endmodule

// >>> sim/aso_tb_top.sv
// Self-checking bench for the converter control block with a sample-level reference model.
`timescale 1ns/10ps
module aso_tb_top
  import aso_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, routine_trigger = 1'b0, dual_sync_mode = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [31:0] w[2];
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic conv_start, conv_ready, conv_done, converter_on;
  logic [SLOT_W-1:0] conv_channel, c;
  logic [SAMPLE_W-1:0] conv_sample, s;
  logic [RESULT_W-1:0] partner_converter_result = '0, routine_result, exp_r, pr;
  int failures, checks_done, nacc, ndone, ntrig, cnt, acc, res, en, ratio, sh, nps;
  int sl[16];
  bit pend, d, a, dual;

  aso_top dut (.*);
  aso_core_model u_core (.*);

  always #25 aclk = ~aclk;

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input bit hit);
    if (hit) begin
      failures++;
      $display("ERROR %0t: wait timed out", $time);
      print_verdict;
    end
  endtask

  // Ready is raised late so the design must hold its answer for a cycle.
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] r);
    int n = 0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      s_axi_bready <= n > 2 && !(s_axi_bvalid && s_axi_bready);
    end while (!(s_axi_bvalid && s_axi_bready) && n < 99);
    tmo(n >= 99);
    chk(34'(s_axi_bresp), 34'(r));
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] r);
    int n = 0;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      s_axi_rready <= n > 1 && !(s_axi_rvalid && s_axi_rready);
    end while (!(s_axi_rvalid && s_axi_rready) && n < 99);
    tmo(n >= 99);
    chk({s_axi_rresp, s_axi_rdata}, {r, e});
  endtask

  always @(posedge aclk) begin
    d = conv_done;
    s = conv_sample;
    a = conv_start && conv_ready;
    c = conv_channel;
    #1;
    if (pend) chk(routine_result, exp_r);
    pend = 0;
    if (a) chk(c, sl[nacc / nps]);
    nacc += a;
    if (d) begin
      ndone++;
      acc += s >> (2 * res);
      cnt++;
      if (cnt == nps) begin
        exp_r = 16'(acc >> sh);
        pend = 1;
        acc = 0;
        cnt = 0;
      end
    end
  end

  task automatic run(input int len, input logic [31:0] ovs);
    int n = 0;
    int tot;
    bit trg, fire;
    wr(CONTROL_OFS, 32'h0, RESP_OKAY);
    wr(STATUS_OFS, 32'h3, RESP_OKAY);
    wr(OVS_CTRL_OFS, ovs, RESP_OKAY);
    rd(OVS_CTRL_OFS, ovs, RESP_OKAY);
    wr(SEQ_12_15_OFS, 32'(len << SEQ_LEN_LSB), RESP_OKAY);
    en = ovs[0];
    ratio = ovs[4:2];
    sh = ovs[8:5] > 8 ? 8 : ovs[8:5];
    res = ovs[13:12];
    trg = ovs[9] && ovs[0];
    nps = en ? 2 << ratio : 1;
    tot = (len + 1) * nps;
    {nacc, ndone, ntrig, acc, cnt} = '0;
    dual = 1'($urandom);
    pr = 16'($urandom);
    dual_sync_mode <= dual;
    partner_converter_result <= pr;
    wr(CONTROL_OFS, 32'h1, RESP_OKAY);
    chk(converter_on, 1'b1);
    while (ndone < tot && n < 20000) begin
      @(posedge aclk);
      n++;
      fire = ntrig == 0 || trg && ntrig == ndone && n % 8 == 0;
      if (fire && trg) chk(nacc, ntrig);
      ntrig += fire;
      routine_trigger <= fire;
    end
    tmo(n >= 20000);
    repeat (4) @(posedge aclk);
    chk(nacc, tot);
    chk(ntrig, trg ? tot : 1);
    rd(DATA_OFS, {dual ? pr : 16'h0, exp_r}, RESP_OKAY);
    rd(STATUS_OFS, 32'h3, RESP_OKAY);
    $display("test run len %0d ovs %h done", len, ovs);
  endtask

  initial begin
    void'($urandom(32'h61034f14));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SEQ_0_5_OFS, 32'h0, RESP_OKAY);
    rd(DATA_OFS, 32'h0, RESP_OKAY);
    rd(OVS_CTRL_OFS, 32'h0, RESP_OKAY);
    rd(8'h44, 32'h0, RESP_SLVERR);
    w = '{32'h0, 32'h0};
    for (int i = 0; i < 12; i++) begin
      sl[i] = $urandom % 18;
      w[i / 6] |= 32'(sl[i]) << (5 * (i % 6));
    end
    wr(SEQ_0_5_OFS, w[0], RESP_OKAY);
    wr(SEQ_6_11_OFS, w[1], RESP_OKAY);
    wr(SEQ_0_5_OFS, w[0] | 32'h1f, RESP_OKAY);
    rd(SEQ_0_5_OFS, w[0], RESP_OKAY);
    rd(SEQ_6_11_OFS, w[1], RESP_OKAY);
    wr(DATA_OFS, 32'hffff_ffff, RESP_OKAY);
    rd(DATA_OFS, 32'h0, RESP_OKAY);
    $display("test registers done");
    run(11, 32'h0000_101c);
    // Every ratio code once and every resolution code twice, shifts from none up to eight, two in triggered mode.
    for (int i = 0; i < 8; i++)
      run(i % 3, 32'((i % 4) << 12 | (i == 2 || i == 6) << 9 | (i > 0) * (i + 1) << 5 | i << 2 | 1));
    print_verdict;
  end
endmodule
